// file: design/gtr_timer.sv
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module gtr_timer
  import gtr_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // external pin
  input  wire logic        external_trigger_input,
  // interrupt
  output logic             irq
);

  logic [CTRL_WIDTH-1:0] ctrl;
  logic [15:0]           reload_capture_value;
  logic [15:0]           timer_count_value;
  logic [STAT_WIDTH-1:0] status;
  logic [STAT_WIDTH-1:0] mask;
  logic [3:0]            div_cnt;
  logic                  trig_meta;
  logic                  trig_sync;
  logic                  trig_prev;

  logic                  wr_en;
  logic                  rd_en;
  logic                  tick;
  logic                  trig_edge;
  logic                  count_down;
  logic                  reload_ev;
  logic                  capture_ev;
  logic                  reload_irq;
  logic [15:0]           next_count;
  logic [31:0]           next_prdata;
  logic                  addr_ok;

  function automatic logic decoded(input logic [7:0] a);
    decoded = (a == ADDR_CTRL) || (a == ADDR_RELOAD) ||
              (a == ADDR_COUNT) || (a == ADDR_STATUS) ||
              (a == ADDR_MASK);
  endfunction

  // zero-wait slave
  assign pready  = 1'b1;
  assign addr_ok = decoded(paddr);
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en   = psel & penable & pwrite & addr_ok;
  assign rd_en   = psel & penable & ~pwrite & addr_ok;

  // two-flop synchroniser, then edge history
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_prev <= 1'b0;
    end else begin
      trig_meta <= external_trigger_input;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
    end
  end

  // edge polarity selectable; sync samples only
  assign trig_edge = ctrl[CTRL_RISE] ? (trig_sync & ~trig_prev)
                                     : (~trig_sync & trig_prev);

  // prescaler: divide by twelve
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      div_cnt <= DIV_RST;
    end else if (!ctrl[CTRL_RUN]) begin
      div_cnt <= DIV_RST;
    end else if (div_cnt == DIV_LAST) begin
      div_cnt <= DIV_RST;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // divider kept even with prescaler bit set; no faster rate is defined
  assign tick = ctrl[CTRL_RUN] & (div_cnt == DIV_LAST);

  // level picks direction only in up/down auto-reload
  assign count_down = ~ctrl[CTRL_CAPT] & ctrl[CTRL_UPDOWN] &
                      ~trig_sync;

  always_comb begin
    next_count = timer_count_value;
    reload_ev  = 1'b0;
    capture_ev = 1'b0;
    if (ctrl[CTRL_RUN]) begin
      if (ctrl[CTRL_CAPT]) begin
        capture_ev = ctrl[CTRL_EXTEN] & trig_edge;
        if (tick) begin
          if (timer_count_value == COUNT_MAX) begin
            next_count = COUNT_MIN;
            reload_ev  = 1'b1;
          end else begin
            next_count = timer_count_value + 16'h0001;
          end
        end
      end else if (count_down) begin
        if (tick) begin
          if (timer_count_value == reload_capture_value) begin
            next_count = COUNT_MAX;
            reload_ev  = 1'b1;
          end else begin
            next_count = timer_count_value - 16'h0001;
          end
        end
      end else begin
        if (!ctrl[CTRL_UPDOWN] && ctrl[CTRL_EXTEN] && trig_edge) begin
          next_count = reload_capture_value;
          reload_ev  = 1'b1;
        end else if (tick) begin
          if (timer_count_value == COUNT_MAX) begin
            next_count = reload_capture_value;
            reload_ev  = 1'b1;
          end else begin
            next_count = timer_count_value + 16'h0001;
          end
        end
      end
    end
  end

  // counter; a software write wins over a count step
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      timer_count_value <= COUNT_RST;
    end else if (wr_en && paddr == ADDR_COUNT) begin
      timer_count_value <= pwdata[15:0];
    end else begin
      timer_count_value <= next_count;
    end
  end

  // reload/capture register; capture beats a software write
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      reload_capture_value <= RELOAD_RST;
    end else if (capture_ev) begin
      reload_capture_value <= timer_count_value;
    end else if (wr_en && paddr == ADDR_RELOAD) begin
      reload_capture_value <= pwdata[15:0];
    end
  end

  // control and mask
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl <= CTRL_RST;
      mask <= MASK_RST;
    end else if (wr_en) begin
      if (paddr == ADDR_CTRL) begin
        ctrl <= pwdata[CTRL_WIDTH-1:0];
      end
      if (paddr == ADDR_MASK) begin
        mask <= pwdata[STAT_WIDTH-1:0];
      end
    end
  end

  // up/down suppresses reload interrupts
  assign reload_irq = reload_ev &
                      (ctrl[CTRL_CAPT] | ~ctrl[CTRL_UPDOWN]);

  // sticky status, cleared by read; a new event wins over the clear
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      status <= '0;
    end else begin
      status[STAT_RELOAD] <= reload_irq |
        (status[STAT_RELOAD] & ~(rd_en && paddr == ADDR_STATUS));
      status[STAT_CAPT] <= capture_ev |
        (status[STAT_CAPT] & ~(rd_en && paddr == ADDR_STATUS));
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      ADDR_CTRL:   next_prdata[CTRL_WIDTH-1:0] = ctrl;
      ADDR_RELOAD: next_prdata[15:0] = reload_capture_value;
      ADDR_COUNT:  next_prdata[15:0] = timer_count_value;
      ADDR_STATUS: next_prdata[STAT_WIDTH-1:0] = status;
      ADDR_MASK:   next_prdata[STAT_WIDTH-1:0] = mask;
      default:     next_prdata = 32'h0000_0000;
    endcase
  end

  // read data is combinational on paddr, which is not registered; valid in access
  assign prdata = (psel & ~pwrite) ? next_prdata : 32'h0000_0000;

endmodule

// file: inc/gtr_pkg.sv
package gtr_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_RELOAD = 8'h04;
  localparam logic [7:0] ADDR_COUNT  = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_MASK   = 8'h10;
  // control field positions
  localparam int CTRL_RUN    = 0;
  localparam int CTRL_CAPT   = 1;
  localparam int CTRL_UPDOWN = 2;
  localparam int CTRL_EXTEN  = 3;
  localparam int CTRL_RISE   = 4;
  localparam int CTRL_PRESC  = 5;
  localparam int CTRL_WIDTH  = 6;
  // status field positions
  localparam int STAT_RELOAD = 0;
  localparam int STAT_CAPT   = 1;
  localparam int STAT_WIDTH  = 2;
  // reset values
  localparam logic [5:0]  CTRL_RST   = 6'h00;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [1:0]  MASK_RST   = 2'h0;
  localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
  localparam logic [15:0] COUNT_MIN  = 16'h0000;
  // prescaler off: one count per twelve clocks
  localparam int          DIV_RATIO  = 12;
  localparam logic [3:0]  DIV_LAST   = 4'(DIV_RATIO - 1);
  localparam logic [3:0]  DIV_RST    = 4'h0;
endpackage

// file: bench/gtr_chk_sva.sv
`timescale 1ns/10ps
module gtr_chk
  import gtr_pkg::*;
(
  // clock, reset, apb
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pin, interrupt
  input wire logic        external_trigger_input,
  input wire logic        irq
);
  logic [5:0] ctrl;
  logic [1:0] mask;
  logic       wr;
  logic       rd;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  // shadows of software state, so reads can be judged
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl <= CTRL_RST;
      mask <= MASK_RST;
    end else if (wr && paddr == ADDR_CTRL) begin
      ctrl <= pwdata[5:0];
    end else if (wr && paddr == ADDR_MASK) begin
      mask <= pwdata[1:0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  chk_ready_high: assert property (psel && penable |-> pready)
    else $error("ready low");
  chk_unmapped_err: assert property (psel && penable && paddr > ADDR_MASK
    |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (psel && penable && paddr[1:0] == 2'h0 &&
    paddr <= ADDR_MASK |-> !pslverr)
    else $error("mapped access refused");
  chk_ctrl_back: assert property (rd && paddr == ADDR_CTRL |->
    prdata == {26'h0, ctrl})
    else $error("ctrl readback");
  chk_count_width: assert property (rd && paddr == ADDR_COUNT |->
    prdata[31:16] == 16'h0)
    else $error("count wider than 16 bits");
  chk_status_width: assert property (rd && paddr == ADDR_STATUS |->
    prdata[31:2] == 30'h0)
    else $error("status upper bits");
  chk_mask_gate: assert property ((mask == 2'h0) [*2] |-> !irq)
    else $error("irq while masked");
  chk_irq_follows: assert property (rd && penable && paddr == ADDR_STATUS &&
    (prdata[1:0] & mask) != 2'h0 |=> irq)
    else $error("irq missing");
endmodule
bind gtr_timer gtr_chk i_chk (.clock, .rst_b, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .external_trigger_input, .irq);

// file: bench/tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module tb;
  import gtr_pkg::*;
  logic        clock, rst_b, psel, penable, pwrite, trig, pready, slverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rq, rnd;
  int          error_cnt, compares, cyc, t0, mc, mr, md;
  gtr_timer i_dut (.clock(clock), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(slverr),
    .external_trigger_input(trig), .irq(irq));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // model modes: 0 up from reload, 1 down to reload, 2 capture from zero
  task automatic ticks(input int n);
    repeat (n) begin
      if (md == 1) mc = (mc == mr) ? 'hFFFF : mc - 1;
      else mc = (mc == 'hFFFF) ? ((md == 2) ? 0 : mr) : mc + 1;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'(d);
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rq = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // sample mid-period so the divider phase cannot sway the result
  task automatic rd_at(input int k, input logic [7:0] a);
    while (cyc < t0 + 12 * k + 3) @(posedge clock);
    apb(1'b0, a, 0);
  endtask
  task automatic run(input int c);
    apb(1'b1, ADDR_CTRL, c);
    t0 = cyc;
  endtask
  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {rst_b, psel, penable, pwrite, trig, paddr, pwdata} = 45'h0;
    cyc = 0;
    rnd = lfsr(32'hda32);
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    for (int a = 0; a <= 'h14; a += 4) begin
      apb(1'b0, 8'(a), 0);
      `CHK(rq, 32'h0)
      `CHK(slverr, 1'(a == 'h14))
    end
    $display("done: reset values");
    mr = 'h4000 + int'(rnd[13:0]);
    mc = 'hFFFE;
    apb(1'b1, ADDR_RELOAD, mr);
    apb(1'b1, ADDR_COUNT, mc);
    apb(1'b1, ADDR_MASK, 1);
    run(1);
    ticks(3);
    rd_at(3, ADDR_COUNT);
    `CHK(rq, 32'(mc))
    `CHK(irq, 1'b1)
    apb(1'b0, ADDR_STATUS, 0);
    `CHK(rq, 32'h1)
    repeat (2) @(posedge clock);
    `CHK(irq, 1'b0)
    ticks(1);
    rd_at(4, ADDR_COUNT);
    `CHK(rq, 32'(mc))
    run(0);
    rd_at(3, ADDR_COUNT);
    `CHK(rq, 32'(mc))
    $display("done: auto-reload and halt");
    run('h19);
    trig <= 1'b1;
    rd_at(0, ADDR_COUNT);
    `CHK(rq, 32'(mr))
    apb(1'b0, ADDR_STATUS, 0);
    `CHK(rq, 32'h1)
    run(0);
    trig <= 1'b0;
    md = 1;
    mc = mr + 2;
    apb(1'b1, ADDR_COUNT, mc);
    run('h1D);
    ticks(4);
    rd_at(4, ADDR_COUNT);
    `CHK(rq, 32'(mc))
    trig <= 1'b1;
    apb(1'b0, ADDR_STATUS, 0);
    `CHK(rq, 32'h0)
    md = 0;
    ticks(2);
    rd_at(6, ADDR_COUNT);
    `CHK(rq, 32'(mc))
    `CHK(irq, 1'b0)
    $display("done: up/down");
    run(0);
    md = 2;
    mc = 'hFFFF;
    apb(1'b1, ADDR_MASK, 3);
    apb(1'b1, ADDR_COUNT, mc);
    run('h0B);
    ticks(3);
    rd_at(3, ADDR_COUNT);
    `CHK(rq, 32'(mc))
    trig <= 1'b0;
    repeat (6) @(posedge clock);
    `CHK(irq, 1'b1)
    apb(1'b0, ADDR_STATUS, 0);
    `CHK(rq, 32'h3)
    apb(1'b0, ADDR_RELOAD, 0);
    `CHK(rq, 32'(mc))
    $display("done: capture");
    wrap_up;
  end
  initial begin
    repeat (3000) @(posedge clock);
    error_cnt++;
    wrap_up;
  end
endmodule
